// File: ttpc_top.sv
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`include "ttpc_consts.svh"
module ttpc_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        timer_zero_pin_i,
	output logic             timer_zero_pin_o,
	output logic             timer_zero_pin_oe,
	input  wire logic        timer_one_pin_i,
	output logic             timer_one_pin_o,
	output logic             timer_one_pin_oe,
	input  wire logic        timer_two_pin_i,
	output logic             timer_two_pin_o,
	output logic             timer_two_pin_oe,
	output logic             irq
);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	ttpc_pkg::ttpc_state_t st_reg;
	ttpc_pkg::ttpc_state_t st_next;
	logic [2:0]            pin_in;

	assign pin_in = {timer_two_pin_i, timer_one_pin_i, timer_zero_pin_i};

	// Pulls one word of a timer's control/status view together.
	function automatic logic [31:0] cs_word(ttpc_pkg::ttpc_timer_t t);
		logic [31:0] w;
		w = 32'h00000000;
		w[`TTPC_CS_ENABLE] = t.ctrl.enable;
		w[`TTPC_CS_MODE_HI:`TTPC_CS_MODE_LO] = t.ctrl.mode;
		w[`TTPC_CS_TIMER_IO] = t.ctrl.timer_io;
		w[`TTPC_CS_GP_DIR] = t.ctrl.gp_dir;
		w[`TTPC_CS_GP_OUT] = t.ctrl.gp_out;
		w[`TTPC_CS_PIN_IN] = t.pin_last;
		w[`TTPC_CS_DIR_OUT] = t.dir_out;
		w[`TTPC_CS_PIN_OUT] = t.pin_out;
		return w;
	endfunction

	// Merges write data into a word under the byte strobes.
	function automatic logic [31:0] merge(logic [31:0] old,
		logic [31:0] data, logic [3:0] strb);
		logic [31:0] w;
		w = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				w[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return w;
	endfunction

	function automatic logic input_mode(ttpc_pkg::ttpc_mode_t m);
		return (m == ttpc_pkg::TTPC_MODE_EVENT) ||
			(m == ttpc_pkg::TTPC_MODE_MEASURE);
	endfunction

	always_comb begin
		logic [2:0]   ev;
		logic [31:0]  wd;
		logic [31:0]  rd;
		logic         tick;
		logic         edge_seen;
		logic         hit;
		logic [1:0]   sel;
		logic         run;
		logic         do_w;
		st_next = st_reg;
		ev = 3'b000;
		wd = 32'h00000000;
		rd = 32'h00000000;
		tick = 1'b0;
		edge_seen = 1'b0;
		hit = 1'b0;
		sel = 2'b00;
		run = 1'b0;
		do_w = 1'b0;

		// --------------------------------------------------------------------
		// Timers
		// --------------------------------------------------------------------
		for (int i = 0; i < `TTPC_NUM_TIMERS; i++) begin
			// An edge of one timer's pin must never count for the next one.
			edge_seen = 1'b0;
			// Three-stage pin synchroniser; input ignored while stopped.
			if (!st_reg.stop) begin
				st_next.tmr[i].sync = {st_reg.tmr[i].sync[1:0], pin_in[i]};
				if (st_reg.tmr[i].sync[2] == st_reg.tmr[i].sync[1]) begin
					st_next.tmr[i].pin_last = st_reg.tmr[i].sync[1];
					edge_seen = st_reg.tmr[i].sync[1] &
						~st_reg.tmr[i].pin_last;
				end
			end
			// Direction follows the function selected in own register.
			if (!st_reg.tmr[i].ctrl.timer_io) begin
				st_next.tmr[i].dir_out = st_reg.tmr[i].ctrl.gp_dir;
				if (!st_reg.stop) begin
					st_next.tmr[i].pin_out = st_reg.tmr[i].ctrl.gp_out;
				end
			end else if (input_mode(st_reg.tmr[i].ctrl.mode)) begin
				st_next.tmr[i].dir_out = 1'b0;
			end else begin
				st_next.tmr[i].dir_out = 1'b1;
			end
			// Counting; wait state does not disturb the timers.
			run = st_reg.tmr[i].ctrl.enable & ~st_reg.stop;
			if (st_reg.tmr[i].ctrl.mode == ttpc_pkg::TTPC_MODE_EVENT) begin
				tick = edge_seen;
			end else if (st_reg.tmr[i].ctrl.mode ==
				ttpc_pkg::TTPC_MODE_MEASURE) begin
				tick = st_reg.tmr[i].pin_last;
			end else begin
				tick = 1'b1;
			end
			if (run && tick) begin
				hit = (st_reg.tmr[i].count == st_reg.tmr[i].load);
				if (hit) begin
					st_next.tmr[i].count = 32'h00000000;
					ev[i] = 1'b1;
					if (st_reg.tmr[i].ctrl.timer_io &&
						!input_mode(st_reg.tmr[i].ctrl.mode)) begin
						if (st_reg.tmr[i].ctrl.mode ==
							ttpc_pkg::TTPC_MODE_TIMER) begin
							st_next.tmr[i].pin_out = 1'b1;
						end else begin
							st_next.tmr[i].pin_out =
								~st_reg.tmr[i].pin_out;
						end
					end
				end else begin
					st_next.tmr[i].count = st_reg.tmr[i].count + 32'h00000001;
				end
			end
		end

		// --------------------------------------------------------------------
		// Register bus
		// --------------------------------------------------------------------
		if (s_axi_awvalid && !st_reg.aw_held &&
			st_reg.wstate == ttpc_pkg::TTPC_BUS_IDLE) begin
			st_next.aw_held = 1'b1;
			st_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_reg.w_held &&
			st_reg.wstate == ttpc_pkg::TTPC_BUS_IDLE) begin
			st_next.w_held = 1'b1;
			st_next.wdata = s_axi_wdata;
			st_next.wstrb = s_axi_wstrb;
		end
		do_w = st_reg.aw_held & st_reg.w_held;
		if (do_w) begin
			st_next.aw_held = 1'b0;
			st_next.w_held = 1'b0;
			st_next.wstate = ttpc_pkg::TTPC_BUS_BRESP;
			st_next.bad_w = 1'b0;
			sel = st_reg.awaddr[5:4];
			if (st_reg.awaddr[11:6] == 6'h00 && sel != 2'b11) begin
				if (st_reg.awaddr[3:0] == `TTPC_OFS_CTRL0) begin
					wd = merge(cs_word(st_reg.tmr[sel]), st_reg.wdata,
						st_reg.wstrb);
					st_next.tmr[sel].ctrl.enable = wd[`TTPC_CS_ENABLE];
					st_next.tmr[sel].ctrl.mode = ttpc_pkg::ttpc_mode_t'(
						wd[`TTPC_CS_MODE_HI:`TTPC_CS_MODE_LO]);
					st_next.tmr[sel].ctrl.timer_io = wd[`TTPC_CS_TIMER_IO];
					st_next.tmr[sel].ctrl.gp_dir = wd[`TTPC_CS_GP_DIR];
					st_next.tmr[sel].ctrl.gp_out = wd[`TTPC_CS_GP_OUT];
					st_next.tmr[sel].count = 32'h00000000;
				end else if (st_reg.awaddr[3:0] == `TTPC_OFS_LOAD0) begin
					st_next.tmr[sel].load = merge(st_reg.tmr[sel].load,
						st_reg.wdata, st_reg.wstrb);
				end else if (st_reg.awaddr[3:0] != `TTPC_OFS_CNT0) begin
					st_next.bad_w = 1'b1;
				end
			end else if (st_reg.awaddr == `TTPC_OFS_IRQ_MSK) begin
				st_next.irq_mask = st_reg.wdata[2:0];
			end else if (st_reg.awaddr == `TTPC_OFS_POWER) begin
				st_next.stop = st_reg.wdata[`TTPC_PWR_STOP];
				st_next.wait_st = st_reg.wdata[`TTPC_PWR_WAIT];
			end else if (st_reg.awaddr != `TTPC_OFS_IRQ_ST) begin
				st_next.bad_w = 1'b1;
			end
		end
		if (st_reg.wstate == ttpc_pkg::TTPC_BUS_BRESP && s_axi_bready) begin
			st_next.wstate = ttpc_pkg::TTPC_BUS_IDLE;
		end

		// Sticky status: write-one clears, a new event wins.
		if (do_w && st_reg.awaddr == `TTPC_OFS_IRQ_ST) begin
			st_next.irq_status = (st_reg.irq_status & ~st_reg.wdata[2:0]) | ev;
		end else begin
			st_next.irq_status = st_reg.irq_status | ev;
		end

		if (s_axi_arvalid && !st_reg.rvalid) begin
			st_next.rvalid = 1'b1;
			st_next.bad_r = 1'b0;
			sel = s_axi_araddr[5:4];
			if (s_axi_araddr[11:6] == 6'h00 && sel != 2'b11) begin
				if (s_axi_araddr[3:0] == `TTPC_OFS_CTRL0) begin
					rd = cs_word(st_reg.tmr[sel]);
				end else if (s_axi_araddr[3:0] == `TTPC_OFS_LOAD0) begin
					rd = st_reg.tmr[sel].load;
				end else if (s_axi_araddr[3:0] == `TTPC_OFS_CNT0) begin
					rd = st_reg.tmr[sel].count;
				end else begin
					st_next.bad_r = 1'b1;
				end
			end else if (s_axi_araddr == `TTPC_OFS_IRQ_ST) begin
				rd = {29'h00000000, st_reg.irq_status};
			end else if (s_axi_araddr == `TTPC_OFS_IRQ_MSK) begin
				rd = {29'h00000000, st_reg.irq_mask};
			end else if (s_axi_araddr == `TTPC_OFS_POWER) begin
				rd = {30'h00000000, st_reg.wait_st, st_reg.stop};
			end else begin
				st_next.bad_r = 1'b1;
			end
			st_next.rdata = rd;
		end else if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end

		if (!aresetn) begin
			st_next = '0;
			for (int i = 0; i < `TTPC_NUM_TIMERS; i++) begin
				st_next.tmr[i].ctrl = ttpc_pkg::ttpc_ctrl_t'(7'h00);
				st_next.tmr[i].load = `TTPC_LOAD_RESET;
			end
		end
	end

	always_ff @(posedge aclk) begin
		st_reg <= st_next;
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	// While stopped the driver keeps the last level on the pin.
	assign timer_zero_pin_o  = st_reg.tmr[0].pin_out;
	assign timer_zero_pin_oe = st_reg.tmr[0].dir_out;
	assign timer_one_pin_o   = st_reg.tmr[1].pin_out;
	assign timer_one_pin_oe  = st_reg.tmr[1].dir_out;
	assign timer_two_pin_o   = st_reg.tmr[2].pin_out;
	assign timer_two_pin_oe  = st_reg.tmr[2].dir_out;

	assign irq = |(st_reg.irq_status & st_reg.irq_mask);

	assign s_axi_awready = ~st_reg.aw_held &
		(st_reg.wstate == ttpc_pkg::TTPC_BUS_IDLE);
	assign s_axi_wready  = ~st_reg.w_held &
		(st_reg.wstate == ttpc_pkg::TTPC_BUS_IDLE);
	assign s_axi_bvalid  = (st_reg.wstate == ttpc_pkg::TTPC_BUS_BRESP);
	assign s_axi_bresp   = st_reg.bad_w ? 2'h2 : 2'h0;
	assign s_axi_arready = ~st_reg.rvalid;
	assign s_axi_rvalid  = st_reg.rvalid;
	assign s_axi_rdata   = st_reg.rdata;
	assign s_axi_rresp   = st_reg.bad_r ? 2'h2 : 2'h0;

endmodule

// File: ttpc_consts.svh
`ifndef TTPC_CONSTS_SVH
`define TTPC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define TTPC_OFS_CTRL0   12'h000
`define TTPC_OFS_CTRL1   12'h010
`define TTPC_OFS_CTRL2   12'h020
`define TTPC_OFS_LOAD0   12'h004
`define TTPC_OFS_LOAD1   12'h014
`define TTPC_OFS_LOAD2   12'h024
`define TTPC_OFS_CNT0    12'h008
`define TTPC_OFS_CNT1    12'h018
`define TTPC_OFS_CNT2    12'h028
`define TTPC_OFS_IRQ_ST  12'h030
`define TTPC_OFS_IRQ_MSK 12'h034
`define TTPC_OFS_POWER   12'h038
`define TTPC_TIMER_STEP  12'h010

// ----------------------------------------------------------------------------
// Control/status field positions
// ----------------------------------------------------------------------------
`define TTPC_CS_ENABLE   0
`define TTPC_CS_MODE_LO  1
`define TTPC_CS_MODE_HI  3
`define TTPC_CS_TIMER_IO 4
`define TTPC_CS_GP_DIR   5
`define TTPC_CS_GP_OUT   6
`define TTPC_CS_EXT_CLK  7
`define TTPC_CS_PIN_IN   8
`define TTPC_CS_DIR_OUT  9
`define TTPC_CS_PIN_OUT  10
`define TTPC_CS_WIDTH    11

`define TTPC_PWR_STOP    0
`define TTPC_PWR_WAIT    1

// ----------------------------------------------------------------------------
// Reset values and number of timers
// ----------------------------------------------------------------------------
`define TTPC_CS_RESET    11'h000
`define TTPC_LOAD_RESET  32'h0000FFFF
`define TTPC_NUM_TIMERS  3

`endif

// File: ttpc_pkg.sv
package ttpc_pkg;

	typedef enum logic [2:0] {
		TTPC_MODE_TIMER    = 3'b000,
		TTPC_MODE_PULSE    = 3'b001,
		TTPC_MODE_WATCHDOG = 3'b010,
		TTPC_MODE_EVENT    = 3'b011,
		TTPC_MODE_MEASURE  = 3'b100
	} ttpc_mode_t;

	typedef enum logic [1:0] {
		TTPC_BUS_IDLE  = 2'b00,
		TTPC_BUS_BRESP = 2'b01,
		TTPC_BUS_RRESP = 2'b10
	} ttpc_bus_t;

	typedef struct packed {
		logic       gp_out;
		logic       gp_dir;
		logic       timer_io;
		ttpc_mode_t mode;
		logic       enable;
	} ttpc_ctrl_t;

	typedef struct packed {
		ttpc_ctrl_t  ctrl;
		logic [31:0] load;
		logic [31:0] count;
		logic [2:0]  sync;
		logic        pin_last;
		logic        pin_out;
		logic        dir_out;
	} ttpc_timer_t;

	typedef struct packed {
		ttpc_timer_t [2:0] tmr;
		logic [2:0]        irq_status;
		logic [2:0]        irq_mask;
		logic              stop;
		logic              wait_st;
		ttpc_bus_t         wstate;
		logic              rvalid;
		logic [31:0]       rdata;
		logic              bad_w;
		logic              bad_r;
		logic              aw_held;
		logic              w_held;
		logic [11:0]       awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
	} ttpc_state_t;

endpackage

// File: ttpc_far_end.sv
`timescale 1ns/10ps
// ----------------------------------------
// Event source and driven device
// ----------------------------------------
module ttpc_far_end (
	input  wire logic [2:0] pin_oe,
	input  wire logic [2:0] pin_o,
	input  wire logic [2:0] ev,
	output logic      [2:0] pin_i
);
	// Each wire shows the timer while it drives, else the event source.
	assign pin_i = (pin_oe & pin_o) | (~pin_oe & ev);
endmodule

// File: ttpc_properties.sv
`timescale 1ns/10ps
module ttpc_properties (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic       timer_zero_pin_oe,
	input wire logic       timer_one_pin_oe,
	input wire logic       timer_two_pin_oe,
	input wire logic       irq
);
	logic [2:0] since_w_reg;
	logic [2:0] since_w_next;
	wire  [2:0] oe = {timer_two_pin_oe, timer_one_pin_oe, timer_zero_pin_oe};
	// Counts cycles since the last write data beat, saturating at seven.
	always_comb begin
		since_w_next = since_w_reg;
		if (s_axi_wvalid && s_axi_wready)
			since_w_next = 3'h0;
		else if (since_w_reg != 3'h7)
			since_w_next = since_w_reg + 3'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			since_w_reg <= 3'h7;
		else
			since_w_reg <= since_w_next;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	pins_reset_a: assert property (disable iff (1'b0) !aresetn |=> oe == 3'h0 && !irq)
		else $error("pins not released by reset");
	write_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
		else $error("write response missing");
	read_answer_a: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
		else $error("read response missing");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	write_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	read_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	pin_dir_sw_a: assert property ($changed(oe) |-> since_w_reg < 3'h6)
		else $error("pin direction changed without a register write");
endmodule
bind ttpc_top ttpc_properties u_props (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .timer_zero_pin_oe, .timer_one_pin_oe, .timer_two_pin_oe,
	.irq);

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
	logic aclk = 1'b0, aresetn = 1'b0, irq;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [2:0]  pin_i, pin_o, pin_oe, ev = 3'h0;
	int          err_count = 0, comparisons = 0, t;
	always #10 aclk = ~aclk;
	ttpc_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.timer_zero_pin_i(pin_i[0]), .timer_zero_pin_o(pin_o[0]),
		.timer_zero_pin_oe(pin_oe[0]), .timer_one_pin_i(pin_i[1]),
		.timer_one_pin_o(pin_o[1]), .timer_one_pin_oe(pin_oe[1]),
		.timer_two_pin_i(pin_i[2]), .timer_two_pin_o(pin_o[2]),
		.timer_two_pin_oe(pin_oe[2]), .irq);
	ttpc_far_end far (.pin_oe, .pin_o, .ev, .pin_i);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic print_verdict();
		if (err_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v,
		input logic [1:0] er);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= v;
		s_axi_wvalid <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bready <= 1'b0;
				chk("bresp", 32'(s_axi_bresp), 32'(er));
				break;
			end
			if (s_axi_bvalid) s_axi_bready <= 1'b1;
		end
		if (i == 40) begin
			err_count++;
			print_verdict();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [1:0] er,
		output logic [31:0] v);
		int i;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rready <= 1'b0;
				v = s_axi_rdata;
				chk("rresp", 32'(s_axi_rresp), 32'(er));
				break;
			end
			if (s_axi_rvalid) s_axi_rready <= 1'b1;
		end
		if (i == 40) begin
			err_count++;
			print_verdict();
		end
	endtask
	task automatic toggles(input int n, output int c);
		logic p;
		c = 0;
		p = pin_o[n];
		repeat (12) begin
			@(posedge aclk);
			if (pin_o[n] !== p) c++;
			p = pin_o[n];
		end
	endtask
	task automatic pulse();
		ev[2] <= 1'b1;
		cyc(4);
		ev[2] <= 1'b0;
		cyc(4);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		cyc(10);
		aresetn <= 1'b1;
		chk("oe", 32'(pin_oe), 32'h0);
		rd(12'h000, 2'b00, d);
		chk("ctrl0", d, 32'h0);
		rd(12'h004, 2'b00, d);
		chk("load0", d, 32'h0000FFFF);
		wr(12'h0FC, 32'h1, 2'b10);
		rd(12'h0FC, 2'b10, d);
		for (int n = 0; n < 3; n++) begin
			wr(12'(n * 16), 32'h60, 2'b00);
			cyc(3);
			chk("oe", 32'(pin_oe), 32'(1 << n));
			chk("o", 32'(pin_o), 32'(1 << n));
			wr(12'(n * 16), 32'h0, 2'b00);
		end
		for (int m = 0; m < 5; m++) begin
			wr(12'h000, 32'h10 | 32'(m << 1), 2'b00);
			cyc(3);
			chk("oe0", 32'(pin_oe[0]), 32'(m < 3));
		end
		wr(12'h004, 32'h3, 2'b00);
		wr(12'h034, 32'h1, 2'b00);
		wr(12'h000, 32'h11, 2'b00);
		for (t = 0; t < 40 && irq !== 1'b1; t++) cyc(1);
		chk("irq", 32'(irq), 32'h1);
		if (t == 40) print_verdict();
		cyc(1);
		chk("o0", 32'(pin_o[0]), 32'h1);
		wr(12'h000, 32'h10, 2'b00);
		wr(12'h030, 32'h1, 2'b00);
		rd(12'h030, 2'b00, d);
		chk("status", d, 32'h0);
		wr(12'h024, 32'h1, 2'b00);
		wr(12'h020, 32'h17, 2'b00);
		pulse();
		pulse();
		rd(12'h030, 2'b00, d);
		chk("status", d, 32'h4);
		chk("irq", 32'(irq), 32'h0);
		wr(12'h014, 32'h2, 2'b00);
		wr(12'h010, 32'h13, 2'b00);
		toggles(1, t);
		chk("toggles", 32'(t), 32'h4);
		wr(12'h038, 32'h1, 2'b00);
		cyc(2);
		toggles(1, t);
		chk("toggles", 32'(t), 32'h0);
		pulse();
		rd(12'h028, 2'b00, d);
		chk("count2", d, 32'h0);
		wr(12'h038, 32'h2, 2'b00);
		cyc(2);
		toggles(1, t);
		chk("toggles", 32'(t), 32'h4);
		chk("oe", 32'(pin_oe), 32'h3);
		wr(12'h024, 32'hFF, 2'b00);
		wr(12'h020, 32'h19, 2'b00);
		ev[2] <= 1'b1;
		cyc(10);
		ev[2] <= 1'b0;
		cyc(6);
		rd(12'h028, 2'b00, d);
		chk("count2", d, 32'hA);
		chk("oe2", 32'(pin_oe[2]), 32'h0);
		print_verdict();
	end
endmodule
